// File: rtl/fwsr_pkg.sv
// constants, types and register map of the flash write-status host controller
package fwsr_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int REG_AW = 4;
  // register offsets of the software port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR_LO = 4'h1;
  localparam logic [3:0] REG_ADDR_HI = 4'h2;
  localparam logic [3:0] REG_WDATA = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_RSTCMD = 4'h6;
  // control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_STOP = 3;
  localparam int CTRL_HV = 4;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_OK = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REJ = 3;
  localparam int ST_ABAND = 4;
  localparam int ST_LIMIT = 5;
  // status bits and the reset command word on the flash data bus
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_LIMIT = 5;
  localparam int DQ_WINDOW = 3;
  localparam logic [15:0] RSTCMD_RESET = 16'h00F0;
  // timing, figures in ns, counts rounded up at the clock rate
  localparam int CLK_MHZ = 250;
  localparam int T_WP_NS = 50;
  localparam int T_ACC_NS = 70;
  localparam int T_REC_NS = 20;
  localparam logic [4:0] WP_CYC = 5'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] ACC_CYC = 5'((T_ACC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] REC_CYC = 5'((T_REC_NS * CLK_MHZ + 999) / 1000);
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_POLL,
    OP_ERASE_ADD
  } fwsr_op_t;
endpackage : fwsr_pkg

// File: rtl/fwsr_cyc_if.sv
// single flash bus cycle request between sequencer and cycle engine
`timescale 1ns/1ps
interface fwsr_cyc_if;
  logic req;
  logic wr;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport seq (output req, output wr, output addr, output wdata,
    input rdata, input done);
  modport eng (input req, input wr, input addr, input wdata,
    output rdata, output done);
endinterface : fwsr_cyc_if

// File: rtl/fwsr_cycle.sv
// flash bus cycle engine: one timed read or write on the flash pins
`timescale 1ns/1ps
module fwsr_cycle
  import fwsr_pkg::*;
(
  input logic clk,
  input logic rst,
  fwsr_cyc_if.eng cyc,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [17:0] fl_addr,
  input logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe_n
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_REC} fwsr_eng_t;
  fwsr_eng_t st_r;
  logic [4:0] cnt_r;
  logic wr_r;
  logic [15:0] rdata_r;

  assign cyc.done = (st_r == E_REC) && (cnt_r == 5'h01);
  assign cyc.rdata = rdata_r;

  // sequencing: setup, strobe of fixed width, recovery
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= E_IDLE;
      cnt_r <= 5'h00;
      wr_r <= 1'b0;
    end else begin
      unique case (st_r)
        E_IDLE: begin
          if (cyc.req) begin
            st_r <= E_SETUP;
            wr_r <= cyc.wr;
          end
        end
        E_SETUP: begin
          st_r <= E_STROBE;
          cnt_r <= wr_r ? WP_CYC : ACC_CYC;
        end
        E_STROBE: begin
          if (cnt_r == 5'h01) begin
            st_r <= E_REC;
            cnt_r <= REC_CYC;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        E_REC: begin
          if (cnt_r == 5'h01) begin
            st_r <= E_IDLE;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
      endcase
    end
  end

  // pins: the write strobe only falls with select low and output enable
  // high, and its width is far above the glitch filter of the part
  always_ff @(posedge clk) begin
    if (rst) begin
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      fl_addr <= '0;
      dq_out <= 16'h0000;
      dq_oe_n <= 1'b1;
    end else begin
      unique case (st_r)
        E_IDLE: begin
          if (cyc.req) begin
            ce_n <= 1'b0;
            fl_addr <= cyc.addr;
            dq_out <= cyc.wdata;
            dq_oe_n <= !cyc.wr;
          end
        end
        E_SETUP: begin
          if (wr_r) begin
            we_n <= 1'b0;
          end else begin
            oe_n <= 1'b0;
          end
        end
        E_STROBE: begin
          if (cnt_r == 5'h01) begin
            // every read ends with select and output enable rising,
            // which is what advances the part's toggle bit
            we_n <= 1'b1;
            oe_n <= 1'b1;
            ce_n <= 1'b1;
          end
        end
        E_REC: dq_oe_n <= 1'b1; // data held one cycle past the strobe
      endcase
    end
  end

  // read data taken just before output enable rises
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (st_r == E_STROBE && cnt_r == 5'h01 && !wr_r) begin
      rdata_r <= dq_in;
    end
  end

  write_inhibit_a: assert property (
    @(posedge clk) disable iff (rst) !we_n |-> (oe_n && !ce_n && !dq_oe_n))
    else $error("write strobe low without select or with output enable");
endmodule : fwsr_cycle

// File: rtl/fwsr_host.sv
// flash write-status host: register port, polling sequencer, cycle engine
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module fwsr_host
  import fwsr_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic [3:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic [17:0] fl_addr,
  input logic [15:0] fl_dq_in,
  output logic [15:0] fl_dq_out,
  output logic fl_dq_oe_n,
  output logic hv_unprotect_req
);
  typedef enum logic [3:0] {
    S_IDLE, S_CRD, S_CWR, S_RD1, S_RD2, S_DECIDE, S_RSTW,
    S_EA_RD1, S_EA_WR, S_EA_RD2
  } fwsr_state_t;

  fwsr_state_t state_r;
  fwsr_cyc_if cyc ();
  logic [17:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rstcmd_r;
  logic [15:0] rdata_r;
  logic [15:0] samp1_r;
  logic [15:0] samp2_r;
  logic hv_r;
  logic stop_r;
  logic second_r;
  logic ok_r;
  logic fail_r;
  logic rej_r;
  logic aband_r;
  logic limit_r;
  logic start;
  logic ctrl_wr;
  logic tog_diff;
  fwsr_op_t op;

  assign ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
  assign start = ctrl_wr && reg_wdata[CTRL_START] && (state_r == S_IDLE);
  assign op = fwsr_op_t'(reg_wdata[CTRL_OP_LSB +: 2]);
  assign tog_diff = samp1_r[DQ_TOGGLE] != samp2_r[DQ_TOGGLE];
  assign hv_unprotect_req = hv_r;

  // cycle requests follow the sequencer state
  assign cyc.req = (state_r != S_IDLE) && (state_r != S_DECIDE);
  assign cyc.wr = (state_r == S_CWR) || (state_r == S_RSTW) ||
    (state_r == S_EA_WR);
  assign cyc.addr = addr_r;
  assign cyc.wdata = (state_r == S_RSTW) ? rstcmd_r : wdata_r;

  fwsr_cycle u_cycle (
    .clk(clk),
    .rst(rst),
    .cyc(cyc),
    .ce_n(fl_ce_n),
    .we_n(fl_we_n),
    .oe_n(fl_oe_n),
    .fl_addr(fl_addr),
    .dq_in(fl_dq_in),
    .dq_out(fl_dq_out),
    .dq_oe_n(fl_dq_oe_n)
  );

  // software-written settings
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= '0;
      wdata_r <= 16'h0000;
      rstcmd_r <= RSTCMD_RESET;
      hv_r <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: hv_r <= reg_wdata[CTRL_HV];
        REG_ADDR_LO: addr_r[15:0] <= reg_wdata;
        REG_ADDR_HI: addr_r[17:16] <= reg_wdata[1:0];
        REG_WDATA: wdata_r <= reg_wdata;
        REG_RSTCMD: rstcmd_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // stop request: leaves polling at the next toggling pair with the limit flag low
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_r <= 1'b0;
    end else if (ctrl_wr && reg_wdata[CTRL_STOP] && state_r != S_IDLE) begin
      stop_r <= 1'b1;
    end else if (state_r == S_IDLE) begin
      stop_r <= 1'b0;
    end
  end

  // sequencer; every poll starts over at the first read pair
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      second_r <= 1'b0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (start) begin
            second_r <= 1'b0;
            unique case (op)
              OP_READ: state_r <= S_CRD;
              OP_WRITE: state_r <= S_CWR;
              OP_POLL: state_r <= S_RD1;
              OP_ERASE_ADD: state_r <= S_EA_RD1;
            endcase
          end
        end
        S_CRD, S_CWR, S_RSTW, S_EA_RD2: begin
          if (cyc.done) state_r <= S_IDLE;
        end
        S_RD1: if (cyc.done) state_r <= S_RD2;
        S_RD2: if (cyc.done) state_r <= S_DECIDE;
        S_DECIDE: begin
          if (!tog_diff) begin
            state_r <= S_IDLE;
          end else if (second_r) begin
            state_r <= S_RSTW;
          end else if (samp2_r[DQ_LIMIT]) begin
            state_r <= S_RD1;
            second_r <= 1'b1;
          end else if (stop_r) begin
            state_r <= S_IDLE;
          end else begin
            state_r <= S_RD1;
          end
        end
        S_EA_RD1: begin
          // window already closed: the extra command would be ignored
          if (cyc.done) begin
            state_r <= cyc.rdata[DQ_WINDOW] ? S_IDLE : S_EA_WR;
          end
        end
        S_EA_WR: if (cyc.done) state_r <= S_EA_RD2;
      endcase
    end
  end

  // read samples for the toggle comparison and the data register
  always_ff @(posedge clk) begin
    if (rst) begin
      samp1_r <= 16'h0000;
      samp2_r <= 16'h0000;
      rdata_r <= 16'h0000;
    end else if (cyc.done && !cyc.wr) begin
      rdata_r <= cyc.rdata;
      if (state_r == S_RD1) samp1_r <= cyc.rdata;
      if (state_r == S_RD2) samp2_r <= cyc.rdata;
    end
  end

  // outcome flags, cleared by the next start; a start is only taken when
  // idle, so a set and a clear never meet in one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ok_r <= 1'b0;
      fail_r <= 1'b0;
      rej_r <= 1'b0;
      aband_r <= 1'b0;
      limit_r <= 1'b0;
    end else if (start) begin
      ok_r <= 1'b0;
      fail_r <= 1'b0;
      rej_r <= 1'b0;
      aband_r <= 1'b0;
      limit_r <= 1'b0;
    end else begin
      if (state_r == S_DECIDE) begin
        // bit 5 of a settled array word is data, not the limit flag
        if (tog_diff && samp2_r[DQ_LIMIT]) limit_r <= 1'b1;
        if (!tog_diff) ok_r <= 1'b1;
        else if (second_r) fail_r <= 1'b1;
        else if (!samp2_r[DQ_LIMIT] && stop_r) aband_r <= 1'b1;
      end
      if (cyc.done && (state_r == S_CRD || state_r == S_CWR)) ok_r <= 1'b1;
      if (cyc.done && (state_r == S_EA_RD1 || state_r == S_EA_RD2)) begin
        if (cyc.rdata[DQ_WINDOW]) rej_r <= 1'b1;
        else if (state_r == S_EA_RD2) ok_r <= 1'b1;
      end
    end
  end

  // register read, data in the following cycle; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_CTRL: reg_rdata[CTRL_HV] <= hv_r;
          REG_ADDR_LO: reg_rdata <= addr_r[15:0];
          REG_ADDR_HI: reg_rdata[1:0] <= addr_r[17:16];
          REG_WDATA: reg_rdata <= wdata_r;
          REG_RDATA: reg_rdata <= rdata_r;
          REG_STATUS: begin
            reg_rdata[ST_BUSY] <= state_r != S_IDLE;
            reg_rdata[ST_OK] <= ok_r;
            reg_rdata[ST_FAIL] <= fail_r;
            reg_rdata[ST_REJ] <= rej_r;
            reg_rdata[ST_ABAND] <= aband_r;
            reg_rdata[ST_LIMIT] <= limit_r;
          end
          REG_RSTCMD: reg_rdata <= rstcmd_r;
          default: ;
        endcase
      end
    end
  end

  poll_equal_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == S_DECIDE && !tog_diff) |=> (state_r == S_IDLE && ok_r))
    else $error("equal toggle reads did not end the poll as success");

  limit_recheck_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == S_DECIDE && tog_diff && !second_r && samp2_r[DQ_LIMIT])
    |=> (state_r == S_RD1 && second_r) ##1 !fail_r)
    else $error("limit flag high did not start a second toggle check");

  poll_restart_a: assert property (
    @(posedge clk) disable iff (rst)
    (start && op == OP_POLL) |=> (state_r == S_RD1 && !second_r))
    else $error("poll did not restart at its first read");

  reset_after_fail_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == S_DECIDE && tog_diff && second_r)
    |=> (state_r == S_RSTW && cyc.wr && cyc.wdata == rstcmd_r) ##1 fail_r)
    else $error("failed poll not followed by the reset command");

  window_reject_a: assert property (
    @(posedge clk) disable iff (rst)
    (cyc.done && state_r == S_EA_RD2 && cyc.rdata[DQ_WINDOW])
    |=> (rej_r && !ok_r && state_r == S_IDLE))
    else $error("window flag high after extra erase not reported");

  early_window_a: assert property (
    @(posedge clk) disable iff (rst)
    (cyc.done && state_r == S_EA_RD1 && cyc.rdata[DQ_WINDOW])
    |=> (state_r == S_IDLE && rej_r))
    else $error("extra erase sent although window was closed");
endmodule : fwsr_host

// File: verification/fwsr_flash_model.sv
// behavioural flash device: status bits on reads, write capture
`timescale 1ns/1ps
module fwsr_flash_model
  import fwsr_pkg::*;
(
  input logic ce_n,
  input logic we_n,
  input logic oe_n,
  input logic [17:0] addr,
  input logic [15:0] dq_out,
  output logic [15:0] dq_in,
  input logic arm,
  input int arm_reads,
  input logic arm_lim,
  input logic arm_win,
  input logic arm_close,
  output int wr_cnt,
  output int rd_cnt,
  output logic [17:0] wa,
  output logic [15:0] wd
);
  int left = 0;
  logic tog = 1'b0;
  logic lim = 1'b0;
  logic win = 1'b0;
  logic close = 1'b0;
  logic rd_act = 1'b0;
  logic wr_act = 1'b0;
  realtime t0 = 0.0;
  logic [15:0] mem = 16'hffff; // power-up state reads the array
  logic [15:0] rv;
  logic [15:0] last = 16'h0000;

  initial begin
    wr_cnt = 0;
    rd_cnt = 0;
    wa = '0;
    wd = '0;
  end

  // status word while busy, array word otherwise
  assign rv = (left > 0) ?
    {9'h000, tog, lim, 1'b0, win, tog, 2'b00} : mem;
  // no pull on the bus: a released bus must not look like stale data
  assign dq_in = (!ce_n && !oe_n) ? rv : ~last;

  // new operation: status is valid from here on
  always @(posedge arm) begin
    left = arm_reads;
    lim = arm_lim;
    win = arm_win;
    close = arm_close;
  end

  // read and write cycles are framed by the strobe levels
  always @(ce_n or we_n or oe_n) begin
    if (!ce_n && !oe_n) rd_act = 1'b1;
    else if (rd_act) begin
      rd_act = 1'b0;
      last = rv;
      rd_cnt++;
      if (left > 0) begin
        tog = ~tog;
        left--;
      end
    end
    if (!ce_n && !we_n && oe_n) begin
      if (!wr_act) t0 = $realtime;
      wr_act = 1'b1;
    end else if (wr_act) begin
      wr_act = 1'b0;
      if ($realtime - t0 >= 5.0) begin
        wr_cnt++;
        wa = addr;
        wd = dq_out;
        if (dq_out == RSTCMD_RESET) begin
          left = 0;
          lim = 1'b0;
        end else if (left == 0 && !win) mem = dq_out;
        if (close) win = 1'b1;
      end
    end
  end
endmodule : fwsr_flash_model

// File: verification/fwsr_host_test.sv
// self-checking bench of the flash write-status host
`timescale 1ns/1ps
module fwsr_host_test
  import fwsr_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic dq_oe_n;
  logic hv_req;
  logic [17:0] fl_addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic arm = 1'b0;
  int arm_reads = 0;
  logic arm_lim = 1'b0;
  logic arm_win = 1'b0;
  logic arm_close = 1'b0;
  int wr_cnt;
  int rd_cnt;
  logic [17:0] wa;
  logic [15:0] wd;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0001_299b;
  logic [31:0] r;
  logic hv = 1'b0;
  logic [15:0] v;
  logic [17:0] a;
  logic [15:0] d;
  int n0;

  always #2 clk = ~clk;

  fwsr_host dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fl_ce_n(ce_n), .fl_we_n(we_n),
    .fl_oe_n(oe_n), .fl_addr(fl_addr), .fl_dq_in(dq_in),
    .fl_dq_out(dq_out), .fl_dq_oe_n(dq_oe_n), .hv_unprotect_req(hv_req));

  fwsr_flash_model fm (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .addr(fl_addr), .dq_out(dq_out), .dq_in(dq_in), .arm(arm),
    .arm_reads(arm_reads), .arm_lim(arm_lim), .arm_win(arm_win),
    .arm_close(arm_close), .wr_cnt(wr_cnt), .rd_cnt(rd_cnt),
    .wa(wa), .wd(wd));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // control word: hv level, stop, op, start
  function automatic logic [15:0] cw(input logic [1:0] op,
    input logic st, input logic sp);
    return {11'h000, hv, sp, op, st};
  endfunction : cw

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a4, input logic [15:0] d16);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a4;
    reg_wdata <= d16;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a4, output logic [15:0] d16);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a4;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d16 = reg_rdata;
  endtask : rd

  task automatic setm(input int n, input logic l, input logic w,
    input logic c);
    @(posedge clk);
    arm_reads <= n;
    arm_lim <= l;
    arm_win <= w;
    arm_close <= c;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
  endtask : setm

  task automatic setad(input logic [17:0] ad, input logic [15:0] dd);
    wr(REG_ADDR_LO, ad[15:0]);
    wr(REG_ADDR_HI, {14'h0000, ad[17:16]});
    wr(REG_WDATA, dd);
  endtask : setad

  // start an operation, optionally stop it after some status reads
  task automatic go(input logic [1:0] op, input int stop_at);
    int i;
    wr(REG_CTRL, cw(op, 1'b1, 1'b0));
    for (i = 0; i < 4000; i++) begin
      if (i == stop_at) wr(REG_CTRL, cw(op, 1'b0, 1'b1));
      rd(REG_STATUS, v);
      if (v[ST_BUSY] === 1'b0) break;
    end
    if (i == 4000) chk(18'(v[ST_BUSY]), 18'h0_0000);
  endtask : go

  task automatic stat(input logic [15:0] e);
    rd(REG_STATUS, v);
    chk(18'(v & 16'h003e), 18'(e));
  endtask : stat

  task automatic summarize();
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // cut a hang short, well beyond the expected run time
  initial begin
    #400000;
    err_count++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(REG_STATUS, v);
    chk(18'(v), 18'h0_0000);
    rd(REG_RSTCMD, v);
    chk(18'(v), 18'h0_00f0);
    rd(4'hf, v);
    chk(18'(v), 18'h0_0000);
    chk(18'({ce_n, we_n, oe_n, dq_oe_n}), 18'h0_000f);
    // random writes then reads back through the array
    setm(0, 1'b0, 1'b0, 1'b0);
    repeat (4) begin
      r = xs();
      a = r[17:0];
      r = xs();
      d = r[15:0] | 16'h8000;
      setad(a, d);
      n0 = wr_cnt;
      go(OP_WRITE, -1);
      chk(18'(wr_cnt - n0), 18'h0_0001);
      chk(wa, a);
      chk(18'(wd), 18'(d));
      go(OP_READ, -1);
      rd(REG_RDATA, v);
      chk(18'(v), 18'(d));
    end
    // idle device: two equal reads end the poll
    n0 = rd_cnt;
    go(OP_POLL, -1);
    stat(16'h0002);
    chk(18'(rd_cnt - n0), 18'h0_0002);
    // limit flag high, toggling stops on the recheck
    setm(2, 1'b1, 1'b0, 1'b0);
    n0 = wr_cnt;
    go(OP_POLL, -1);
    stat(16'h0022);
    chk(18'(wr_cnt - n0), 18'h0_0000);
    // limit flag high, still toggling: failure and reset command
    setm(1000, 1'b1, 1'b0, 1'b0);
    n0 = wr_cnt;
    go(OP_POLL, -1);
    stat(16'h0024);
    chk(18'(wr_cnt - n0), 18'h0_0001);
    chk(18'(wd), 18'h0_00f0);
    chk(wa, a);
    // abandoned poll, then a fresh poll starts at the first pair
    setm(1000, 1'b0, 1'b0, 1'b0);
    go(OP_POLL, 100);
    stat(16'h0010);
    setm(0, 1'b0, 1'b0, 1'b0);
    n0 = rd_cnt;
    go(OP_POLL, -1);
    stat(16'h0002);
    chk(18'(rd_cnt - n0), 18'h0_0002);
    // erase-add: open window, closed before, closed after
    for (int k = 0; k < 3; k++) begin
      setm(100, 1'b0, k == 1, k == 2);
      n0 = wr_cnt;
      go(OP_ERASE_ADD, -1);
      stat((k > 0) ? 16'h0008 : 16'h0002);
      chk(18'(wr_cnt - n0), (k == 1) ? 18'h0 : 18'h1);
    end
    // high voltage request follows the control bit
    hv = 1'b1;
    wr(REG_CTRL, cw(2'b00, 1'b0, 1'b0));
    repeat (2) @(posedge clk);
    chk(18'(hv_req), 18'h0_0001);
    rd(REG_CTRL, v);
    chk(18'(v[CTRL_HV]), 18'h0_0001);
    hv = 1'b0;
    wr(REG_CTRL, cw(2'b00, 1'b0, 1'b0));
    repeat (2) @(posedge clk);
    chk(18'(hv_req), 18'h0_0000);
    // mid-run reset drops the request, the reset word and the outcome
    hv = 1'b1;
    wr(REG_CTRL, cw(2'b00, 1'b0, 1'b0));
    wr(REG_RSTCMD, 16'h5a5a);
    rd(REG_RSTCMD, v);
    chk(18'(v), 18'h0_5a5a);
    hv = 1'b0;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(18'(hv_req), 18'h0_0000);
    chk(18'({ce_n, we_n, oe_n, dq_oe_n}), 18'h0_000f);
    rd(REG_RSTCMD, v);
    chk(18'(v), 18'h0_00f0);
    rd(REG_STATUS, v);
    chk(18'(v), 18'h0_0000);
    summarize();
  end
endmodule : fwsr_host_test
